/* File: core/eic_edge.sv */
// Rising edge capture for all interrupt lines.
// Assumes the lines come from logic on the same clock.
module eic_edge (
   // Clock and reset
   input wire logic clock_in,
   input wire logic rstn_in,
   // Lines
   input wire logic [31:0] line_in,
   output logic [31:0] rise_out
);
   logic [31:0] prev;
   logic [31:0] next_rise;

   // ----------------------------------------------------------------
   // Per-line detector
   // ----------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < eic_pkg::NUM_LINES; i++) begin : g_line
         always_comb begin
            next_rise[i] = line_in[i] & ~prev[i]; // R1
         end
      end
   endgenerate

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         prev <= eic_pkg::RST_WORD;
         rise_out <= eic_pkg::RST_WORD;
      end else begin
         prev <= line_in;
         rise_out <= next_rise;
      end
   end

   rise_only_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
      rise_out[13] |-> $past(line_in[13], 1) && !$past(line_in[13], 2))
      else $error("edge flagged without a low to high step"); // R1
endmodule // eic_edge

/* File: core/eic_timer.sv */
// Down counting cycle timer that pulses once when its count runs out.
// Assumes load pulses come from the same clock domain.
module eic_timer (
   // Clock and reset
   input wire logic clock_in,
   input wire logic rstn_in,
   // Load
   input wire logic load_in,
   input wire logic [31:0] load_val_in,
   // Status
   output logic [31:0] count_out,
   output logic fire_out
);
   logic [31:0] next_count;
   logic next_fire;

   always_comb begin
      next_count = count_out;
      next_fire = 1'b0;
      if (load_in) begin
         next_count = load_val_in; // R7
      end else if (count_out != 32'h0) begin
         next_count = count_out - 32'h1;
         next_fire = (count_out == 32'h1); // R7
      end
   end

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         count_out <= eic_pkg::RST_WORD;
         fire_out <= 1'b0;
      end else begin
         count_out <= next_count;
         fire_out <= next_fire;
      end
   end

   sequence load_six_s;
      load_in && load_val_in == 32'h6 ##1 (!load_in) [*6];
   endsequence

   timer_expiry_a: assert property (@(posedge clock_in)
      disable iff (!rstn_in) load_six_s |=> fire_out)
      else $error("timer did not fire after its count"); // R7
endmodule // eic_timer

/* File: core/eic_top.sv */
// Edge triggered interrupt controller with mask, enables and timer.
// Assumes a core that pulses take and return on the system clock.
//
// What this block does
// [R1] A request is caught only on a low to high step of its line.
// [R2] There are 32 lines, each with its own pending, mask and enable.
// [R3] While a handler runs no other interrupt is delivered.
// [R4] A mask bit of one blocks its line and a zero lets it through.
// [R5] One line is enabled or disabled by number, others untouched.
// [R6] Control goes through the core's command port, not memory.
// [R7] A loaded count makes the timer fire after that many cycles.
// [R8] On a take the handler gets a word of the lines that fired.
// [R9] Line 0 is the timer and line 1 the breakpoint trap.
// [R10] Line 2 is the misaligned access and line 3 the illegal opcode.
// [R11] Line 4 is the debug module and line 5 the stack guard.
// [R12] Lines 10 to 13 are SPI master, SPI slave, I2C and UART.
// [R13] Lines 20 to 31 belong to user peripherals on extension buses.
// [R14] Reserved lines 6 to 9 and 14 to 19 never raise a request.
module eic_top (
   // Clock and reset
   input wire logic clock_in,
   input wire logic rstn_in,
   // Command port from the core
   input wire logic [3:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [31:0] rdata_out,
   // Core trap sources
   input wire logic ebreak_in,
   input wire logic bus_error_in,
   input wire logic illegal_insn_in,
   input wire logic debug_irq_in,
   input wire logic stack_prot_in,
   // Peripheral sources
   input wire logic spi_master_irq_in,
   input wire logic spi_slave_irq_in,
   input wire logic i2c_irq_in,
   input wire logic uart_irq_in,
   input wire logic [11:0] user_irq_in,
   // Core handshake
   input wire logic take_in,
   input wire logic return_in,
   output logic irq_out,
   output logic busy_out,
   output logic [31:0] vector_out
);

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   logic [1:0] rst_sync;
   logic rstn;

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end

   assign rstn = rst_sync[1];

   // ----------------------------------------------------------------
   // Decoding helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] line_bit(input logic [31:0] num);
      logic [31:0] res;
      res = 32'h0;
      if (num[31:5] == 27'h0) begin
         res[num[4:0]] = 1'b1;
      end
      return res;
   endfunction

   function automatic logic [31:0] gate(input logic [2:0] c);
      return {{31{c[eic_pkg::CTRL_EXT_BIT]}}, c[eic_pkg::CTRL_TMR_BIT]};
   endfunction

   // ----------------------------------------------------------------
   // Line assembly
   // ----------------------------------------------------------------
   logic tmr_fire;
   logic tmr_load;
   logic [31:0] tmr_count;
   logic [31:0] raw;
   logic [31:0] rise;

   always_comb begin
      raw = eic_pkg::RST_WORD; // R14
      raw[eic_pkg::LINE_TIMER] = tmr_fire; // R9
      raw[eic_pkg::LINE_EBREAK] = ebreak_in; // R9
      raw[eic_pkg::LINE_BUS_ERR] = bus_error_in; // R10
      raw[eic_pkg::LINE_ILLEGAL] = illegal_insn_in; // R10
      raw[eic_pkg::LINE_DEBUG] = debug_irq_in; // R11
      raw[eic_pkg::LINE_STACK] = stack_prot_in; // R11
      raw[eic_pkg::LINE_SPI_MST] = spi_master_irq_in; // R12
      raw[eic_pkg::LINE_SPI_SLV] = spi_slave_irq_in; // R12
      raw[eic_pkg::LINE_I2C] = i2c_irq_in; // R12
      raw[eic_pkg::LINE_UART] = uart_irq_in; // R12
      raw[31:eic_pkg::LINE_USER_LO] = user_irq_in; // R13
   end

   eic_edge u_edge (
      .clock_in(clock_in),
      .rstn_in(rstn),
      .line_in(raw),
      .rise_out(rise)
   );

   eic_timer u_timer (
      .clock_in(clock_in),
      .rstn_in(rstn),
      .load_in(tmr_load),
      .load_val_in(wdata_in),
      .count_out(tmr_count),
      .fire_out(tmr_fire)
   );

   // ----------------------------------------------------------------
   // Controller state
   // ----------------------------------------------------------------
   logic [31:0] mask;
   logic [31:0] enables;
   logic [2:0] ctrl;
   logic [31:0] pending;
   logic [31:0] elig;
   logic [31:0] clr;
   eic_pkg::eic_state_t state;
   logic [31:0] next_mask;
   logic [31:0] next_enables;
   logic [2:0] next_ctrl;
   logic [31:0] next_pending;
   logic [31:0] next_vector;
   logic [31:0] next_rdata;
   logic next_irq;
   logic next_busy;
   eic_pkg::eic_state_t next_state;

   assign elig = pending & ~mask & enables & gate(ctrl); // R4

   always_comb begin
      next_mask = mask;
      next_enables = enables;
      next_ctrl = ctrl;
      next_state = state;
      next_busy = busy_out;
      next_vector = vector_out;
      next_rdata = eic_pkg::RST_WORD;
      clr = eic_pkg::RST_WORD;
      tmr_load = 1'b0;
      if (wr_in) begin
         case (addr_in)
            eic_pkg::ADDR_MASK: begin
               next_mask = wdata_in; // R4 R6
            end
            eic_pkg::ADDR_EN_ONE: begin
               next_enables = enables | line_bit(wdata_in); // R5
            end
            eic_pkg::ADDR_DIS_ONE: begin
               next_enables = enables & ~line_bit(wdata_in); // R5
            end
            eic_pkg::ADDR_CTRL: begin
               next_ctrl = wdata_in[eic_pkg::CTRL_W-1:0];
            end
            eic_pkg::ADDR_TIMER: begin
               tmr_load = 1'b1; // R7
            end
            eic_pkg::ADDR_PEND: begin
               clr = wdata_in;
            end
            default: begin
            end
         endcase
      end
      case (state)
         eic_pkg::ST_IDLE: begin
            if (take_in && irq_out) begin
               next_vector = elig; // R8
               clr = clr | elig;
               next_state = eic_pkg::ST_SERVICE;
               next_busy = 1'b1;
            end
         end
         eic_pkg::ST_SERVICE: begin
            if (return_in) begin
               next_state = eic_pkg::ST_IDLE; // R3
               next_busy = 1'b0;
            end
         end
         default: begin
            next_state = eic_pkg::ST_IDLE;
            next_busy = 1'b0;
         end
      endcase
      // A new edge wins over a clear in the same cycle
      next_pending = ((pending & ~clr) | rise) & eic_pkg::LINE_USED; // R2
      next_irq = next_ctrl[eic_pkg::CTRL_GLB_BIT]
         && next_state == eic_pkg::ST_IDLE // R3
         && |(next_pending & ~next_mask & next_enables & gate(next_ctrl));
      if (rd_in) begin
         case (addr_in)
            eic_pkg::ADDR_MASK: next_rdata = mask;
            eic_pkg::ADDR_CTRL: next_rdata = {29'h0, ctrl};
            eic_pkg::ADDR_TIMER: next_rdata = tmr_count;
            eic_pkg::ADDR_PEND: next_rdata = pending;
            eic_pkg::ADDR_VECTOR: next_rdata = vector_out; // R8
            eic_pkg::ADDR_ENABLES: next_rdata = enables;
            default: next_rdata = eic_pkg::RST_WORD;
         endcase
      end
   end

   always_ff @(posedge clock_in or negedge rstn) begin
      if (!rstn) begin
         mask <= eic_pkg::RST_MASK;
         enables <= eic_pkg::RST_ENABLES;
         ctrl <= eic_pkg::RST_CTRL;
         pending <= eic_pkg::RST_WORD;
         state <= eic_pkg::ST_IDLE;
         busy_out <= 1'b0;
         irq_out <= 1'b0;
         vector_out <= eic_pkg::RST_WORD;
         rdata_out <= eic_pkg::RST_WORD;
      end else begin
         mask <= next_mask;
         enables <= next_enables;
         ctrl <= next_ctrl;
         pending <= next_pending;
         state <= next_state;
         busy_out <= next_busy;
         irq_out <= next_irq;
         vector_out <= next_vector;
         rdata_out <= next_rdata;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!rstn);

   sequence take_s;
      state == eic_pkg::ST_IDLE && take_in && irq_out;
   endsequence

   sequence uart_rise_s;
      !uart_irq_in ##1 uart_irq_in;
   endsequence

   pend_capture_a: assert property (uart_rise_s |-> ##2 pending[13])
      else $error("uart edge not held pending"); // R2 R12
   no_nesting_a: assert property (busy_out |-> !irq_out)
      else $error("interrupt offered during service"); // R3
   full_mask_a: assert property (mask == 32'hFFFFFFFF |-> !irq_out)
      else $error("masked lines still interrupt"); // R4
   enable_one_a: assert property (wr_in && addr_in == eic_pkg::ADDR_EN_ONE
      && wdata_in == 32'h5 |=> enables == ($past(enables) | 32'h20))
      else $error("single enable wrong"); // R5
   mask_load_a: assert property (wr_in && addr_in == eic_pkg::ADDR_MASK
      |=> mask == $past(wdata_in))
      else $error("mask command not taken"); // R6
   take_vector_a: assert property (take_s |=> busy_out
      && vector_out == $past(elig))
      else $error("fired lines not handed over"); // R8
   timer_line_a: assert property (tmr_fire |-> ##2 pending[0])
      else $error("timer not on line zero"); // R9
   illegal_line_a: assert property (!illegal_insn_in ##1 illegal_insn_in
      |-> ##2 pending[3])
      else $error("illegal opcode not on line three"); // R10
   stack_line_a: assert property (!stack_prot_in ##1 stack_prot_in
      |-> ##2 pending[5])
      else $error("stack guard not on line five"); // R11
   reserved_idle_a: assert property ((pending & ~eic_pkg::LINE_USED) == 0)
      else $error("reserved line pending"); // R14
endmodule // eic_top

/* File: shared/eic_pkg.sv */
// Constants shared by the edge interrupt controller files.
// Assumes one system clock for the whole controller.
package eic_pkg;
   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int unsigned NUM_LINES = 32;
   localparam int unsigned CTRL_W = 3;

   // ----------------------------------------------------------------
   // Command port offsets
   // ----------------------------------------------------------------
   localparam logic [3:0] ADDR_MASK = 4'h0;
   localparam logic [3:0] ADDR_EN_ONE = 4'h1;
   localparam logic [3:0] ADDR_DIS_ONE = 4'h2;
   localparam logic [3:0] ADDR_CTRL = 4'h3;
   localparam logic [3:0] ADDR_TIMER = 4'h4;
   localparam logic [3:0] ADDR_PEND = 4'h5;
   localparam logic [3:0] ADDR_VECTOR = 4'h6;
   localparam logic [3:0] ADDR_ENABLES = 4'h7;

   // ----------------------------------------------------------------
   // Control field positions
   // ----------------------------------------------------------------
   localparam int unsigned CTRL_EXT_BIT = 0;
   localparam int unsigned CTRL_TMR_BIT = 1;
   localparam int unsigned CTRL_GLB_BIT = 2;

   // ----------------------------------------------------------------
   // Line numbers
   // ----------------------------------------------------------------
   localparam int unsigned LINE_TIMER = 0;
   localparam int unsigned LINE_EBREAK = 1;
   localparam int unsigned LINE_BUS_ERR = 2;
   localparam int unsigned LINE_ILLEGAL = 3;
   localparam int unsigned LINE_DEBUG = 4;
   localparam int unsigned LINE_STACK = 5;
   localparam int unsigned LINE_SPI_MST = 10;
   localparam int unsigned LINE_SPI_SLV = 11;
   localparam int unsigned LINE_I2C = 12;
   localparam int unsigned LINE_UART = 13;
   localparam int unsigned LINE_USER_LO = 20;
   localparam logic [31:0] LINE_USED = 32'hFFF03C3F;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [31:0] RST_MASK = 32'h00000000;
   localparam logic [31:0] RST_ENABLES = 32'h00000000;
   localparam logic [2:0] RST_CTRL = 3'h0;
   localparam logic [31:0] RST_WORD = 32'h00000000;

   typedef enum logic {ST_IDLE, ST_SERVICE} eic_state_t;
endpackage

/* File: test/eic_core_model.sv */
// Core side model: takes an offered interrupt, returns after a hold.
// Assumes irq and busy from the controller on the same clock.
module eic_core_model (
   // Clock and reset
   input wire logic clock_in,
   input wire logic rstn_in,
   // Controller status
   input wire logic irq_in,
   input wire logic busy_in,
   // Bench control
   input wire logic go_in,
   input wire logic [7:0] hold_in,
   // Handshake
   output logic take_out,
   output logic return_out
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt;
   always @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         take_out <= 1'b0;
         return_out <= 1'b0;
         cnt <= 0;
      end else begin
         take_out <= 1'b0;
         return_out <= 1'b0;
         if (cnt > 0) begin
            cnt <= cnt - 1;
            return_out <= (cnt == 1);
         end else if (go_in && irq_in && !busy_in && !return_out) begin
            take_out <= 1'b1;
            cnt <= int'(hold_in) + 1;
         end
      end
   end
endmodule // eic_core_model

/* File: test/tb_top.sv */
// Bench for the edge interrupt controller with a reference model.
// Assumes eic_pkg, eic_top and eic_core_model are compiled first.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock_in = 1'b0;
   logic rstn_in = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic go = 1'b0;
   logic [31:0] src = 32'h0;
   logic [31:0] rdata, vector, elig, rise, seed = 32'h47;
   logic take, ret, irq, busy, m_irq;
   logic [31:0] m_pend = 32'h0, m_prev = 32'h0, m_mask = 32'h0;
   logic [31:0] m_en = 32'h0, m_vec = 32'h0, m_tmr = 32'h0;
   logic [31:0] m_rise = 32'h0;
   logic m_fire = 1'b0;
   logic [2:0] m_ctrl = 3'h0;
   logic m_busy = 1'b0;
   int n_fail = 0;
   int check_count = 0;

   always #12.5 clock_in = ~clock_in;

   eic_top u_dut (.clock_in(clock_in), .rstn_in(rstn_in),
      .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
      .rdata_out(rdata), .ebreak_in(src[1]), .bus_error_in(src[2]),
      .illegal_insn_in(src[3]), .debug_irq_in(src[4]),
      .stack_prot_in(src[5]), .spi_master_irq_in(src[10]),
      .spi_slave_irq_in(src[11]), .i2c_irq_in(src[12]),
      .uart_irq_in(src[13]), .user_irq_in(src[31:20]),
      .take_in(take), .return_in(ret), .irq_out(irq),
      .busy_out(busy), .vector_out(vector));
   eic_core_model u_core (.clock_in(clock_in), .rstn_in(rstn_in),
      .irq_in(irq), .busy_in(busy), .go_in(go), .hold_in(8'h0A),
      .take_out(take), .return_out(ret));

   // ----------------------------------------------------------------
   // Reference model
   // ----------------------------------------------------------------
   assign elig = m_pend & ~m_mask & m_en & {{31{m_ctrl[0]}}, m_ctrl[1]};
   assign m_irq = m_ctrl[2] & (|elig) & ~m_busy;
   assign rise = (src & ~m_prev & eic_pkg::LINE_USED) |
      {31'h0, m_fire};
   always @(posedge clock_in) begin
      if (rstn_in) begin
         m_prev <= src;
         m_rise <= rise;
         m_fire <= !(wr && addr == eic_pkg::ADDR_TIMER) && m_tmr == 32'h1;
         m_pend <= (m_pend & ~((wr && addr == eic_pkg::ADDR_PEND) ?
            wdata : 32'h0) & ~((take && m_irq) ? elig : 32'h0)) | m_rise;
         if (take && m_irq) begin
            m_busy <= 1'b1;
            m_vec <= elig;
         end
         if (ret) m_busy <= 1'b0;
         m_tmr <= (wr && addr == eic_pkg::ADDR_TIMER) ? wdata :
            ((m_tmr != 32'h0) ? m_tmr - 32'h1 : 32'h0);
         if (wr) begin
            case (addr)
               eic_pkg::ADDR_MASK: m_mask <= wdata;
               eic_pkg::ADDR_EN_ONE: if (wdata < 32) m_en[wdata[4:0]] <= 1'b1;
               eic_pkg::ADDR_DIS_ONE: if (wdata < 32) m_en[wdata[4:0]] <= 1'b0;
               eic_pkg::ADDR_CTRL: m_ctrl <= wdata[2:0];
               default: ;
            endcase
         end
      end
   end

   function automatic logic [31:0] mread(input logic [3:0] a);
      case (a)
         eic_pkg::ADDR_MASK: return m_mask;
         eic_pkg::ADDR_CTRL: return {29'h0, m_ctrl};
         eic_pkg::ADDR_TIMER: return m_tmr;
         eic_pkg::ADDR_PEND: return m_pend;
         eic_pkg::ADDR_VECTOR: return m_vec;
         eic_pkg::ADDR_ENABLES: return m_en;
         default: return 32'h0;
      endcase
   endfunction

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr_t(input logic [3:0] a, input logic [31:0] d);
      @(posedge clock_in);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock_in);
      wr <= 1'b0;
   endtask

   task automatic rchk(input logic [3:0] a);
      logic [31:0] e;
      @(posedge clock_in);
      addr <= a;
      rd <= 1'b1;
      #1;
      e = mread(a);
      @(posedge clock_in);
      rd <= 1'b0;
      #1;
      chk($sformatf("reg %h", a), rdata, e);
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clock_in);
      #1;
   endtask

   task automatic wait_busy(input logic v);
      int i;
      i = 0;
      while (busy !== v && i < 60) begin
         @(posedge clock_in);
         #1;
         i++;
      end
      chk("busy", {31'h0, busy}, {31'h0, v});
   endtask

   task automatic stop_test;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      repeat (20) @(posedge clock_in);
      rstn_in <= 1'b1;
      settle(3);
      for (int a = 0; a < 16; a++) rchk(4'(a));
      $display("test reset done");
      wr_t(eic_pkg::ADDR_CTRL, 32'h7);
      for (int n = 0; n < 34; n++) wr_t(eic_pkg::ADDR_EN_ONE, 32'(n));
      wr_t(eic_pkg::ADDR_DIS_ONE, 32'h5);
      wr_t(eic_pkg::ADDR_DIS_ONE, 32'h21);
      rchk(eic_pkg::ADDR_ENABLES);
      rchk(eic_pkg::ADDR_CTRL);
      $display("test enables done");
      repeat (8) begin
         src <= xs() & eic_pkg::LINE_USED & 32'hFFFFFFFE;
         settle(4);
         rchk(eic_pkg::ADDR_PEND);
         chk("irq", {31'h0, irq}, {31'h0, m_irq});
         wr_t(eic_pkg::ADDR_PEND, 32'hFFFFFFFF);
         settle(4);
         rchk(eic_pkg::ADDR_PEND);
      end
      $display("test edges done");
      src <= 32'h0;
      wr_t(eic_pkg::ADDR_PEND, 32'hFFFFFFFF);
      src <= 32'h00002000;
      wr_t(eic_pkg::ADDR_MASK, 32'h00002000);
      settle(4);
      chk("irq", {31'h0, irq}, 32'h0);
      wr_t(eic_pkg::ADDR_MASK, 32'hFFFFDFFF);
      settle(4);
      chk("irq", {31'h0, irq}, 32'h1);
      rchk(eic_pkg::ADDR_MASK);
      wr_t(eic_pkg::ADDR_MASK, 32'h0);
      $display("test mask done");
      go <= 1'b1;
      wait_busy(1'b1);
      chk("vector", vector, m_vec);
      src <= 32'h00102000;
      settle(4);
      chk("irq", {31'h0, irq}, 32'h0);
      rchk(eic_pkg::ADDR_VECTOR);
      wait_busy(1'b0);
      wait_busy(1'b1);
      chk("vector", vector, 32'h00100000);
      go <= 1'b0;
      wait_busy(1'b0);
      $display("test take done");
      wr_t(eic_pkg::ADDR_PEND, 32'hFFFFFFFF);
      wr_t(eic_pkg::ADDR_TIMER, 32'h6);
      rchk(eic_pkg::ADDR_TIMER);
      settle(1);
      rchk(eic_pkg::ADDR_PEND);
      settle(8);
      rchk(eic_pkg::ADDR_PEND);
      chk("irq", {31'h0, irq}, 32'h1);
      $display("test timer done");
      stop_test();
   end

   initial begin
      repeat (20000) @(posedge clock_in);
      n_fail++;
      stop_test();
   end
endmodule // tb_top
